// ==== shared/bls_pkg.sv ====
// Constants and types for the byte-lane bus sizing block.
// Assumes a single 25 MHz clock and a target that answers per cycle.
package bls_pkg;

    // ========================================
    // Operand size codes
    localparam logic [1:0] SZ_BYTE  = 2'h0;
    localparam logic [1:0] SZ_WORD  = 2'h1;
    localparam logic [1:0] SZ_DWORD = 2'h2;

    localparam logic [7:0] MASK_BYTE  = 8'h01;
    localparam logic [7:0] MASK_WORD  = 8'h03;
    localparam logic [7:0] MASK_DWORD = 8'h0F;

    // ========================================
    // Lane patterns, 1 = lane takes part
    localparam logic [3:0] NO_LANES  = 4'h0;
    localparam logic [3:0] ALL_LANES = 4'hF;
    localparam logic [3:0] HALF_HI   = 4'hC;
    localparam logic [3:0] HALF_LO   = 4'h3;
    localparam int         LANE_W    = 8;
    localparam int         DWORD_W   = 32;

    // ========================================
    // Address space
    localparam int          IO_DW_BITS = 14;
    localparam logic [29:0] IO_DW_MASK = 30'h00003FFF;
    localparam logic [29:0] DW_ONE     = 30'h00000001;
    localparam logic [1:0]  FILL_LAST  = 2'h3;
    localparam logic [1:0]  FILL_ONE   = 2'h1;

    // ========================================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_WAIT  = 2'b10
    } bls_state_e;

endpackage

// ==== hdl/bls_bus_sizer.sv ====
// Local-bus transfer sequencer with byte lanes and dynamic sizing.
// Assumes the target holds ready low for 2+ clocks and data stable for 5+ clocks from ready.
`timescale 1ns/1ps
`default_nettype none

module bls_bus_sizer (
    input  wire logic                 clk_sys_i,
    input  wire logic                 reset_i,
    input  wire logic                 req_valid_i,
    output logic                      req_ready_o,
    input  wire logic [31:0]          req_addr_i,
    input  wire logic [1:0]           req_size_i,
    input  wire logic                 req_write_i,
    input  wire logic                 req_io_i,
    input  wire logic                 req_fill_i,
    input  wire logic [31:0]          req_wdata_i,
    output logic                      rsp_valid_o,
    output logic [31:0]               rsp_rdata_o,
    output logic                      fill_word_valid_o,
    output logic                      bus_start_n_o,
    output logic                      bus_write_o,
    output logic                      bus_io_o,
    output logic [29:0]               dword_address_o,
    output logic [3:0]                byte_lane_select_n_o,
    output logic [31:0]               data_lanes_o,
    output logic                      data_lanes_oe_o,
    input  wire logic [31:0]          data_lanes_i,
    input  wire logic                 bus_ready_n_i,
    input  wire logic                 port_size8_n_i,
    input  wire logic                 port_size16_n_i
);
    import bls_pkg::*;

    // ========================================
    // Helpers
    function automatic logic [31:0] lane_bits(input logic [3:0] p);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*LANE_W +: LANE_W] = {LANE_W{p[i]}};
        end
        return m;
    endfunction

    // I/O cycles never leave the 64 Kbyte window
    function automatic logic [29:0] dw_wrap(input logic [29:0] a,
                                            input logic io);
        return io ? (a & IO_DW_MASK) : a;
    endfunction

    function automatic logic [7:0] size_mask(input logic [1:0] sz);
        case (sz)
            SZ_BYTE: size_mask = MASK_BYTE;
            SZ_WORD: size_mask = MASK_WORD;
            default: size_mask = MASK_DWORD;
        endcase
    endfunction

    // ========================================
    // State
    typedef struct packed {
        bls_state_e  st;
        logic [29:0] dwa;
        logic [3:0]  pend;
        logic [3:0]  lo;
        logic        cur_hi;
        logic        wr;
        logic        io;
        logic        fill;
        logic [1:0]  cnt;
        logic [1:0]  shift;
        logic [63:0] wbuf;
        logic [63:0] rbuf;
        logic [31:0] rdata;
        logic        rsp_v;
        logic        fill_v;
        logic        start_n;
        logic [31:0] dout;
        logic        oe;
        logic [2:0]  sy_rdy;
        logic [2:0]  sy_s8;
        logic [2:0]  sy_s16;
        logic        f_rdy;
        logic        f_s8;
        logic        f_s16;
        logic        prev_rdy;
    } bls_state_s;

    bls_state_s  s_r;
    bls_state_s  s_nxt;
    logic        comp;
    logic        sz8;
    logic        sz16;
    logic [3:0]  next_lanes;
    logic [7:0]  op_mask;
    logic [29:0] base_dw;

    // Completion on ready edge, so a long ready counts once
    assign comp = (s_r.st == ST_WAIT) && !s_r.f_rdy && s_r.prev_rdy;
    assign sz8  = !s_r.f_s8;
    assign sz16 = !s_r.f_s16 && !sz8;

    always_comb begin
        next_lanes = NO_LANES;
        if (sz8) begin
            next_lanes = s_r.pend & (s_r.pend - 4'h1);
        end else if (sz16) begin
            if ((s_r.pend & HALF_LO) != NO_LANES) begin
                next_lanes = s_r.pend & HALF_HI;
            end
        end
    end

    assign op_mask = size_mask(req_size_i) << req_addr_i[1:0];
    assign base_dw = dw_wrap(req_addr_i[31:2], req_io_i);

    // ========================================
    // Next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.rsp_v   = 1'b0;
        s_nxt.fill_v  = 1'b0;
        s_nxt.start_n = 1'b1;
        s_nxt.sy_rdy  = {s_r.sy_rdy[1:0], bus_ready_n_i};
        s_nxt.sy_s8   = {s_r.sy_s8[1:0], port_size8_n_i};
        s_nxt.sy_s16  = {s_r.sy_s16[1:0], port_size16_n_i};
        if (s_r.sy_rdy[1] == s_r.sy_rdy[2]) begin
            s_nxt.f_rdy = s_r.sy_rdy[2];
        end
        if (s_r.sy_s8[1] == s_r.sy_s8[2]) begin
            s_nxt.f_s8 = s_r.sy_s8[2];
        end
        if (s_r.sy_s16[1] == s_r.sy_s16[2]) begin
            s_nxt.f_s16 = s_r.sy_s16[2];
        end
        s_nxt.prev_rdy = s_r.f_rdy;

        case (s_r.st)
            ST_IDLE: begin
                if (req_valid_i) begin
                    s_nxt.io    = req_io_i;
                    s_nxt.wr    = req_write_i && !req_fill_i;
                    s_nxt.fill  = req_fill_i;
                    s_nxt.cnt   = '0;
                    s_nxt.shift = req_addr_i[1:0];
                    s_nxt.rbuf  = '0;
                    s_nxt.wbuf  = {32'h0, req_wdata_i} << (req_addr_i[1:0] * LANE_W);
                    if (req_fill_i) begin
                        s_nxt.dwa    = {base_dw[29:2], 2'h0};
                        s_nxt.pend   = ALL_LANES;
                        s_nxt.lo     = NO_LANES;
                        s_nxt.cur_hi = 1'b0;
                    end else if (op_mask[7:4] != NO_LANES) begin
                        // Upper dword first: it holds the high-order bytes
                        s_nxt.dwa    = dw_wrap(base_dw + DW_ONE, req_io_i);
                        s_nxt.pend   = op_mask[7:4];
                        s_nxt.lo     = op_mask[3:0];
                        s_nxt.cur_hi = 1'b1;
                    end else begin
                        s_nxt.dwa    = base_dw;
                        s_nxt.pend   = op_mask[3:0];
                        s_nxt.lo     = NO_LANES;
                        s_nxt.cur_hi = 1'b0;
                    end
                    s_nxt.st = ST_START;
                end
            end
            ST_START: begin
                s_nxt.start_n = 1'b0;
                s_nxt.st      = ST_WAIT;
            end
            ST_WAIT: begin
                if (comp) begin
                    for (int i = 0; i < 4; i++) begin
                        if (s_r.pend[i]) begin
                            s_nxt.rbuf[(s_r.cur_hi ? DWORD_W : 0) + i*LANE_W +: LANE_W] =
                                data_lanes_i[i*LANE_W +: LANE_W];
                        end
                    end
                    s_nxt.st = ST_START;
                    if (next_lanes != NO_LANES) begin
                        s_nxt.pend = next_lanes;
                    end else if (s_r.lo != NO_LANES) begin
                        s_nxt.dwa    = dw_wrap(s_r.dwa - DW_ONE, s_r.io);
                        s_nxt.pend   = s_r.lo;
                        s_nxt.lo     = NO_LANES;
                        s_nxt.cur_hi = 1'b0;
                    end else if (s_r.fill) begin
                        s_nxt.fill_v = 1'b1;
                        s_nxt.rdata  = s_nxt.rbuf[31:0];
                        s_nxt.rbuf   = '0;
                        if (s_r.cnt == FILL_LAST) begin
                            s_nxt.rsp_v = 1'b1;
                            s_nxt.st    = ST_IDLE;
                        end else begin
                            s_nxt.cnt  = s_r.cnt + FILL_ONE;
                            s_nxt.dwa  = s_r.dwa + DW_ONE;
                            s_nxt.pend = ALL_LANES;
                        end
                    end else begin
                        s_nxt.rsp_v = 1'b1;
                        s_nxt.rdata = 32'(s_nxt.rbuf >> (s_r.shift * LANE_W));
                        s_nxt.st    = ST_IDLE;
                    end
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase

        // Lanes negated in a cycle carry zero; in ST_IDLE the last pend bytes stay on them, with oe low
        s_nxt.dout = lane_bits(s_nxt.pend) &
                     (s_nxt.cur_hi ? s_nxt.wbuf[63:32] : s_nxt.wbuf[31:0]);
        s_nxt.oe   = s_nxt.wr && (s_nxt.st != ST_IDLE);
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            s_r          <= '0;
            s_r.start_n  <= 1'b1;
            s_r.sy_rdy   <= 3'h7;
            s_r.sy_s8    <= 3'h7;
            s_r.sy_s16   <= 3'h7;
            s_r.f_rdy    <= 1'b1;
            s_r.f_s8     <= 1'b1;
            s_r.f_s16    <= 1'b1;
            s_r.prev_rdy <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ========================================
    // Outputs
    assign req_ready_o          = (s_r.st == ST_IDLE);
    assign rsp_valid_o          = s_r.rsp_v;
    assign rsp_rdata_o          = s_r.rdata;
    assign fill_word_valid_o    = s_r.fill_v;
    assign bus_start_n_o        = s_r.start_n;
    assign bus_write_o          = s_r.wr;
    assign bus_io_o             = s_r.io;
    assign dword_address_o      = s_r.dwa;
    assign byte_lane_select_n_o = (s_r.st == ST_IDLE) ? ALL_LANES : ~s_r.pend;
    assign data_lanes_o         = s_r.dout;
    assign data_lanes_oe_o      = s_r.oe;

    // ========================================
    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    logic [3:0] act;
    assign act = ~byte_lane_select_n_o;

    lanes_contig_a: assert property ((s_r.st != ST_IDLE) |->
        (act != NO_LANES) && (((act + (act & (~act + 4'h1))) & act) == NO_LANES))
        else $error("lane selects not contiguous");

    size8_step_a: assert property (comp && sz8 && (next_lanes != NO_LANES)
        |=> ($countones(s_r.pend) + 1 == $countones($past(s_r.pend))))
        else $error("8-bit sizing dropped wrong lane count");

    both_sizes_a: assert property (comp && !s_r.f_s8 && !s_r.f_s16 &&
        ($countones(s_r.pend) > 1) |=> ##1 !bus_start_n_o &&
        ($countones(act) + 1 == $countones($past(s_r.pend, 2))))
        else $error("both sizes not taken as 8-bit");

    size16_step_a: assert property (comp && sz16 && (s_r.pend[1:0] != 2'h0) &&
        (s_r.pend[3:2] != 2'h0) |=> (s_r.pend == ($past(s_r.pend) & HALF_HI)))
        else $error("16-bit sizing wrong next pattern");

    addr_hold_a: assert property (comp && (next_lanes != NO_LANES)
        |=> $stable(dword_address_o) ##1 !bus_start_n_o)
        else $error("dword address moved in sizing cycle");

    follow_on_a: assert property (!bus_start_n_o |=> !comp ##1 bus_start_n_o)
        else $error("start not followed by wait");

    io_window_a: assert property (bus_io_o && (s_r.st != ST_IDLE)
        |-> (dword_address_o[29:IO_DW_BITS] == '0))
        else $error("I/O cycle outside 64 Kbytes");

    write_lanes_a: assert property (data_lanes_oe_o
        |-> ((data_lanes_o & ~lane_bits(act)) == 32'h0))
        else $error("write data on negated lane");

    high_first_a: assert property ((s_r.lo != NO_LANES) && (s_r.st != ST_IDLE)
        |-> s_r.cur_hi)
        else $error("low dword sent before high");

    start_hold_a: assert property (!bus_start_n_o |->
        (act != NO_LANES) && $stable(dword_address_o) && $stable(byte_lane_select_n_o))
        else $error("address or lanes moved at cycle start");

    eight_bit_cyc_c: cover property (comp && sz8 && (s_r.pend == HALF_HI));
    split_op_c: cover property (comp && (s_r.lo != NO_LANES));
    size16_cyc_c: cover property (comp && sz16 && (s_r.pend == ALL_LANES));
    fill_done_c: cover property (s_r.fill_v && rsp_valid_o);

endmodule

`default_nettype wire

// ==== sim/bls_target_model.sv ====
// Target model: byte memory behind 32-, 16- and 8-bit ports, prompt or slow ready.
// Assumes dword address bits 5:4 pick the port width: 32, 16, 8, both pins low.
`timescale 1ns/1ps
`default_nettype none

module bls_target_model (
    input  wire logic        clk_sys_i,
    input  wire logic        slow_i,
    input  wire logic        bus_start_n_i,
    input  wire logic        bus_write_i,
    input  wire logic [29:0] dword_address_i,
    input  wire logic [3:0]  byte_lane_select_n_i,
    input  wire logic [31:0] wdata_i,
    output logic [31:0]      rdata_o,
    output logic             ready_n_o,
    output logic             size8_n_o,
    output logic             size16_n_o,
    output int               errs_o
);
    logic [7:0]  mem [256];
    logic [29:0] adr;
    logic [3:0]  sel;
    logic [1:0]  low_addr;
    logic [3:0]  served;
    logic        low_byte_strobe_n;
    logic        high_byte_strobe_n;
    int          cnt = 0;
    int          dly = 3;
    // ============================================================
    // One cycle: wait, ready low four clocks, data kept a little longer
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i * 32'h7 + 32'h11);
        {ready_n_o, size8_n_o, size16_n_o} = 3'h7;
        rdata_o = 32'h5A3C_96E1;
        errs_o = 0;
    end
    always @(negedge clk_sys_i) begin
        if (bus_start_n_i === 1'b0) begin
            if (cnt > 0 && cnt <= dly + 4) errs_o++;
            cnt = 1;
            dly = slow_i ? 7 : 3;
            adr = dword_address_i;
            sel = byte_lane_select_n_i;
            low_addr = !sel[0] ? 2'h0 : (!sel[1] ? 2'h1 : (!sel[2] ? 2'h2 : 2'h3));
            low_byte_strobe_n = sel[{low_addr[1], 1'b0}];
            high_byte_strobe_n = sel[{low_addr[1], 1'b1}];
            rdata_o = ~rdata_o;
        end else if (cnt > 0) begin
            cnt++;
        end
        if (cnt > dly && cnt <= dly + 4 && {adr, sel} !== {dword_address_i, byte_lane_select_n_i})
            errs_o++;
        if (cnt == dly) begin
            size16_n_o = ~adr[4];
            size8_n_o = ~adr[5];
            // A narrow port serves only the lanes its own decode picks
            case (adr[5:4])
                2'h0: served = ~sel;
                2'h1: served = 4'({~high_byte_strobe_n, ~low_byte_strobe_n})
                               << {low_addr[1], 1'b0};
                default: served = 4'h1 << low_addr;
            endcase
            for (int k = 0; k < 4; k++)
                if (served[k]) rdata_o[8*k +: 8] = mem[{adr[5:0], 2'(k)}];
            ready_n_o = 1'b0;
        end
        if (cnt == dly + 4) begin
            for (int k = 0; k < 4; k++)
                if (served[k] && bus_write_i) mem[{adr[5:0], 2'(k)}] = wdata_i[8*k +: 8];
            {ready_n_o, size8_n_o, size16_n_o} = 3'h7;
        end
        if (cnt == dly + 12) begin
            // Released lanes must not keep the last byte
            rdata_o = ~rdata_o;
            cnt = 0;
        end
    end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Bench for the bus sizer: lane sequences, narrow ports, writes, fills, I/O wrap.
// Assumes the target model picks port width from dword address bits 5:4.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import bls_pkg::*;
    logic        clk_sys_i, reset_i, req_valid_i, req_write_i, req_io_i, req_fill_i, slow;
    logic        req_ready_o, rsp_valid_o, fill_word_valid_o, bus_start_n_o, bus_write_o;
    logic        bus_io_o, data_lanes_oe_o, ready_n, size8_n, size16_n;
    logic [1:0]  req_size_i;
    logic [3:0]  byte_lane_select_n_o, sel;
    logic [29:0] dword_address_o;
    logic [31:0] req_addr_i, req_wdata_i, rsp_rdata_o, data_lanes_o, rdata;
    logic [7:0]  shadow [256];
    logic [35:0] exp_q[$], got_q[$];
    int          n_errors = 0, compares = 0, cyc = 0, model_errs;

    bls_bus_sizer dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_addr_i(req_addr_i), .req_size_i(req_size_i),
        .req_write_i(req_write_i), .req_io_i(req_io_i), .req_fill_i(req_fill_i),
        .req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
        .fill_word_valid_o(fill_word_valid_o), .bus_start_n_o(bus_start_n_o),
        .bus_write_o(bus_write_o), .bus_io_o(bus_io_o), .dword_address_o(dword_address_o),
        .byte_lane_select_n_o(byte_lane_select_n_o), .data_lanes_o(data_lanes_o),
        .data_lanes_oe_o(data_lanes_oe_o), .data_lanes_i(rdata), .bus_ready_n_i(ready_n),
        .port_size8_n_i(size8_n), .port_size16_n_i(size16_n));
    bls_target_model tgt_u (.clk_sys_i(clk_sys_i), .slow_i(slow), .bus_start_n_i(bus_start_n_o),
        .bus_write_i(bus_write_o), .dword_address_i(dword_address_o),
        .byte_lane_select_n_i(byte_lane_select_n_o), .wdata_i(data_lanes_o), .rdata_o(rdata),
        .ready_n_o(ready_n), .size8_n_o(size8_n), .size16_n_o(size16_n), .errs_o(model_errs));

    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // ============================================================
    // Checking helpers and the closing report
    task automatic chk(logic ok, string msg);
        compares++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask
    task automatic conclude();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            conclude();
        end
    end
    // Next select pattern of a sized dword; F means no further cycle
    function automatic logic [3:0] nxt(logic [3:0] p, logic [1:0] rg);
        if (rg == 2'h0) return 4'hF;
        if (rg == 2'h1) return (p[1:0] != 2'h3 && p[3:2] != 2'h3) ? (p | 4'h3) : 4'hF;
        return ($countones(p) == 3) ? 4'hF : (p | (~p & (p + 4'h1)));
    endfunction
    task automatic add_dw(logic [29:0] d, logic [3:0] p, logic wr, logic io);
        while (p != 4'hF) begin
            exp_q.push_back({io, wr, d, p});
            p = nxt(p, d[5:4]);
        end
    endtask
    always @(negedge clk_sys_i) begin
        if (!reset_i && bus_start_n_o === 1'b0) begin
            got_q.push_back({bus_io_o, bus_write_o, dword_address_o, byte_lane_select_n_o});
            sel = ~byte_lane_select_n_o;
            chk(!(sel inside {4'h0, 4'h5, 4'h9, 4'hA, 4'hB, 4'hD}), "lane run");
            if (bus_write_o === 1'b1)
                chk(data_lanes_oe_o && !(data_lanes_o & ~{{8{sel[3]}}, {8{sel[2]}},
                    {8{sel[1]}}, {8{sel[0]}}}), "idle lane data");
        end
    end
    // ============================================================
    // One request, predicted cycle by cycle, then judged
    task automatic op(logic [31:0] a, logic [1:0] sz, logic wr, logic io, logic fl,
                      logic [31:0] wd);
        logic [31:0] hi, am, ex, m;
        int          len, n, fw;
        am = io ? 32'h0000_FFFF : 32'hFFFF_FFFF;
        len = fl ? 16 : 1 << sz;
        hi = (a + len - 1) & am;
        exp_q.delete();
        got_q.delete();
        if (fl) begin
            for (int d = 0; d < 4; d++) add_dw({a[31:4], 2'(d)}, 4'h0, 1'b0, 1'b0);
        end else if (hi[31:2] != a[31:2]) begin
            add_dw(hi[31:2], ~(4'hF >> (3 - hi[1:0])), wr, io);
            add_dw(a[31:2], ~(4'hF << a[1:0]), wr, io);
        end else begin
            add_dw(a[31:2], ~((4'hF << a[1:0]) & (4'hF >> (3 - hi[1:0]))), wr, io);
        end
        {ex, m} = 64'h0;
        for (int k = 0; k < 4 && k < len; k++) begin
            ex[8*k +: 8] = shadow[fl ? 8'({a[7:4], 4'hC} + k) : 8'((a + k) & am)];
            m[8*k +: 8] = wr ? 8'h00 : 8'hFF;
        end
        // Writes return nothing worth judging
        ex = ex & m;
        @(negedge clk_sys_i);
        chk(req_ready_o === 1'b1, "not ready");
        {req_addr_i, req_size_i, req_write_i, req_io_i, req_fill_i} = {a, sz, wr, io, fl};
        req_wdata_i = wd;
        req_valid_i = 1'b1;
        slow = ~slow;
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
        {n, fw} = 64'h0;
        while (rsp_valid_o !== 1'b1 && n < 3000) begin
            @(negedge clk_sys_i);
            n++;
            if (fill_word_valid_o === 1'b1) fw++;
        end
        chk(n < 3000 && fw == (fl ? 4 : 0), "answer or fill pulses");
        chk((rsp_rdata_o & m) === ex, "read data");
        chk(got_q.size() == exp_q.size(), "cycle count");
        foreach (exp_q[i]) chk(got_q[i] === exp_q[i], "cycle lanes or address");
        if (wr)
            for (int k = 0; k < len; k++) shadow[8'((a + k) & am)] = wd[8*k +: 8];
    endtask
    task automatic sc_sizes();
        for (int r = 0; r < 4; r++)
            for (int s = 0; s < 3; s++)
                for (int o = 0; o < 4; o++)
                    op(r * 32'h40 + 32'h10 + o, 2'(s), 1'b0, 1'b0, 1'b0, 32'h0);
    endtask
    task automatic sc_writes();
        for (int r = 0; r < 4; r++) begin
            op(r * 32'h40 + 32'h21, SZ_DWORD, 1'b1, 1'b0, 1'b0, 32'hC3A5_7E19);
            op(r * 32'h40 + 32'h2B, SZ_WORD, 1'b1, 1'b0, 1'b0, 32'h0000_B24D);
            op(r * 32'h40 + 32'h2E, SZ_BYTE, 1'b1, 1'b0, 1'b0, 32'h0000_0066);
            for (int d = 0; d < 4; d++)
                op(r * 32'h40 + 32'h20 + d * 4, SZ_DWORD, 1'b0, 1'b0, 1'b0, 32'h0);
        end
    endtask
    task automatic sc_fill_wrap();
        for (int r = 0; r < 4; r++)
            op(r * 32'h40 + 32'h33, SZ_DWORD, 1'b0, 1'b0, 1'b1, 32'h0);
        op(32'h0000_FFFD, SZ_DWORD, 1'b1, 1'b1, 1'b0, 32'h1234_5678);
        op(32'h0000_FFFE, SZ_DWORD, 1'b0, 1'b1, 1'b0, 32'h0);
        op(32'hFFFF_FFFF, SZ_WORD, 1'b0, 1'b0, 1'b0, 32'h0);
    endtask
    initial begin
        {req_valid_i, req_write_i, req_io_i, req_fill_i, slow} = 5'h0;
        {req_addr_i, req_size_i, req_wdata_i} = 66'h0;
        for (int i = 0; i < 256; i++) shadow[i] = 8'(i * 32'h7 + 32'h11);
        reset_i = 1'b1;
        repeat (10) @(negedge clk_sys_i);
        reset_i = 1'b0;
        sc_sizes();
        sc_writes();
        sc_fill_wrap();
        chk(model_errs == 0, "target saw a broken cycle");
        conclude();
    end
endmodule
`default_nettype wire
